// file: hdl/mtj_meter_ctrl.sv
// measurement sequencing, auto-range, zero adjust and comparator judgment
//
// Behaviour
// - internal source ignores external and remote triggers, except for storage pulses.
// - external trigger source forces automatic result memory off.
// - internal source with continuous on starts measurements back to back.
// - external source gives at most one measurement per trigger event; events arriving while one is pending merge.
// - continuous off: triggers accepted only after the host arms an acquisition.
// - thresholds entered locally select the range from reference or upper value.
// - thresholds from remote commands leave the range unchanged.
// - normal mode picks the smallest range whose bound covers the value.
// - 30.10 to 120.00 megohm selects 100 megohm, the top range.
// - voltage limiting shifts kilohm and megohm bounds down, all but the 100 megohm top.
// - reduced power offers 1000 milliohm to 1000 ohm, top up to 1200 ohm.
// - zero adjustment cancels an offset of at most 10 ohm.
// - larger offset is rejected and raises the zero-adjustment error.
// - Hi above upper, IN between limits inclusive, Lo below lower.
// - positive over-range judges Hi, negative over-range judges Lo.
// - a measurement fault yields no judgment.
// - judgments are driven only once limits have been configured.
// - edited settings apply only on confirmation; otherwise old ones stay.
// - judgment tone off after reset, sounds only when enabled.
// - comparator disabled means no judgment outputs.
// - outside zero adjustment, faults other than over-range assert the fault output.
`timescale 1ns/1ps
module mtj_meter_ctrl
    import mtj_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       externalTriggerSource,
    input  wire logic       contMeasure,
    input  wire logic       externalTriggerInput,
    input  wire logic       remoteTrig,
    input  wire logic       hostArm,
    input  wire logic       autoMemReq,
    input  wire logic       lowPower,
    input  wire logic       voltLimit,
    input  wire logic       rangeWr,
    input  wire mtj_range_t rangeVal,
    input  wire logic       compEnable,
    input  wire mtj_val_t   editUpper,
    input  wire mtj_val_t   editLower,
    input  wire mtj_val_t   editRef,
    input  wire logic       editRefMode,
    input  wire logic       editFromPanel,
    input  wire logic       editConfirm,
    input  wire logic       zeroStart,
    input  wire logic       zeroErrClr,
    input  wire logic       beepEnWr,
    input  wire logic       beepEnVal,
    input  wire logic       measDone,
    input  wire mtj_val_t   measValue,
    input  wire logic       overRangePositive,
    input  wire logic       overRangeNegative,
    input  wire logic       measFault,
    output logic            measStart,
    output logic            measBusy,
    output logic            measZero,
    output mtj_range_t      rangeSel,
    output logic            autoMemEn,
    output logic            storeTrig,
    output mtj_val_t        offsetVal,
    output logic            zeroErr,
    output logic            limitsValid,
    output logic            judgeHi,
    output logic            judgeIn,
    output logic            judgeLo,
    output logic            judgeValid,
    output logic            faultOut,
    output logic            beep
);

    typedef struct packed {
        mtj_state_t st;
        logic       sync1;
        logic       sync2;
        logic       trigPrev;
        logic       pend;
        logic       armed;
        logic       isZero;
        mtj_range_t rangeIdx;
        mtj_val_t   limHi;
        mtj_val_t   limLo;
        logic       limValid;
        mtj_val_t   offset;
        logic       zeroErr;
        logic       beepEn;
        logic       autoMem;
        logic       jHi;
        logic       jIn;
        logic       jLo;
        logic       jValid;
        logic       fault;
        logic       beep;
        logic       start;
        logic       store;
    } mtj_ctrl_t;

    localparam mtj_ctrl_t CTRL_RESET = '{
        st:       ST_IDLE,
        rangeIdx: RANGE_RESET,
        default:  '0
    };

    mtj_ctrl_t  s_reg;
    mtj_ctrl_t  s_next;
    mtj_range_t autoRange;
    mtj_val_t   adjValue;
    logic       trigEvent;
    logic       compOn;
    logic       startNorm;
    logic       isHi;
    logic       isLo;

    // threshold entry picks reference in REF% mode, upper limit otherwise
    mtj_range_select u_range (
        .value     (editRefMode ? editRef : editUpper),
        .lowPower  (lowPower),
        .voltLimit (voltLimit),
        .rangeIdx  (autoRange)
    );

    // only the synchronised copy feeds the edge detector
    assign trigEvent = (s_reg.sync2 & ~s_reg.trigPrev) | remoteTrig;
    assign compOn    = compEnable & s_reg.limValid;

    // internal source free-runs or waits for an arm; external needs a held event
    assign startNorm = externalTriggerSource ? s_reg.pend
                                             : (contMeasure | s_reg.armed);

    // offset is subtracted with a floor at zero
    assign adjValue = (measValue >= s_reg.offset) ? (measValue - s_reg.offset) : '0;

    assign isHi = overRangePositive | (~overRangeNegative & (adjValue > s_reg.limHi));
    assign isLo = ~isHi & (overRangeNegative | (adjValue < s_reg.limLo));

    always_comb begin
        s_next = s_reg;
        s_next.sync1    = externalTriggerInput;
        s_next.sync2    = s_reg.sync1;
        s_next.trigPrev = s_reg.sync2;
        s_next.start    = 1'b0;
        s_next.beep     = 1'b0;
        // storage and statistics see every trigger in either source mode
        s_next.store    = trigEvent;
        s_next.autoMem  = autoMemReq & ~externalTriggerSource;

        if (beepEnWr) begin
            s_next.beepEn = beepEnVal;
        end

        if (contMeasure) begin
            s_next.armed = 1'b0;
        end else if (hostArm) begin
            s_next.armed = 1'b1;
        end

        if (rangeWr) begin
            s_next.rangeIdx = rangeVal;
        end

        // nothing edited reaches the live limits before confirmation
        if (editConfirm) begin
            s_next.limHi    = editUpper;
            s_next.limLo    = editLower;
            s_next.limValid = 1'b1;
            if (editFromPanel) begin
                s_next.rangeIdx = autoRange;
            end
        end

        if (zeroErrClr) begin
            s_next.zeroErr = 1'b0;
        end

        case (s_reg.st)
            ST_IDLE: begin
                if (zeroStart) begin
                    s_next.st     = ST_MEAS;
                    s_next.isZero = 1'b1;
                    s_next.start  = 1'b1;
                end else if (startNorm) begin
                    s_next.st     = ST_MEAS;
                    s_next.isZero = 1'b0;
                    s_next.start  = 1'b1;
                    s_next.pend   = 1'b0;
                    // an arm arriving as the last one is consumed is kept
                    s_next.armed  = hostArm & ~contMeasure;
                    s_next.jHi    = 1'b0;
                    s_next.jIn    = 1'b0;
                    s_next.jLo    = 1'b0;
                    s_next.jValid = 1'b0;
                    s_next.fault  = 1'b0;
                end
            end
            ST_MEAS: begin
                if (measDone) begin
                    s_next.st = ST_IDLE;
                    if (s_reg.isZero) begin
                        if (!measFault && !overRangePositive && !overRangeNegative
                            && measValue <= ZERO_LIMIT) begin
                            s_next.offset = measValue;
                        end else begin
                            s_next.zeroErr = 1'b1;
                        end
                    end else begin
                        s_next.fault = measFault;
                        if (!measFault && compOn) begin
                            s_next.jHi    = isHi;
                            s_next.jLo    = isLo;
                            s_next.jIn    = ~isHi & ~isLo;
                            s_next.jValid = 1'b1;
                            s_next.beep   = s_reg.beepEn;
                        end
                    end
                end
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase

        // a trigger in the cycle its pending flag is consumed is kept;
        // one event is held while busy, more than one merge
        if (externalTriggerSource && trigEvent && (contMeasure || s_reg.armed)) begin
            s_next.pend = 1'b1;
        end
        if (!externalTriggerSource) begin
            s_next.pend = 1'b0;
        end

        // disabling the comparator drops any shown judgment at once
        if (!compEnable) begin
            s_next.jHi    = 1'b0;
            s_next.jIn    = 1'b0;
            s_next.jLo    = 1'b0;
            s_next.jValid = 1'b0;
            s_next.beep   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            s_reg <= CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign measStart   = s_reg.start;
    assign measBusy    = (s_reg.st == ST_MEAS);
    assign measZero    = s_reg.isZero;
    assign rangeSel    = s_reg.rangeIdx;
    assign autoMemEn   = s_reg.autoMem;
    assign storeTrig   = s_reg.store;
    assign offsetVal   = s_reg.offset;
    assign zeroErr     = s_reg.zeroErr;
    assign limitsValid = s_reg.limValid;
    assign judgeHi     = s_reg.jHi;
    assign judgeIn     = s_reg.jIn;
    assign judgeLo     = s_reg.jLo;
    assign judgeValid  = s_reg.jValid;
    assign faultOut    = s_reg.fault;
    assign beep        = s_reg.beep;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    logic judgeCycle;
    assign judgeCycle = measBusy && measDone && !s_reg.isZero;

    a_int_no_pend: assert property (
        !externalTriggerSource |=> !s_reg.pend || externalTriggerSource)
        else $error("pending trigger held under internal source");

    a_automem_off: assert property (
        externalTriggerSource |=> !autoMemEn)
        else $error("auto memory on with external source");

    a_free_run: assert property (
        !measBusy && !externalTriggerSource && contMeasure |=> measStart)
        else $error("free run did not start a measurement");

    a_one_per_external_trigger_input: assert property (
        measStart && !measZero && $past(externalTriggerSource) |-> $past(s_reg.pend))
        else $error("external measurement without a trigger");

    a_arm_needed: assert property (
        measStart && !measZero && !$past(contMeasure) |-> $past(s_reg.armed))
        else $error("measurement started without host arm");

    a_panel_range: assert property (
        editConfirm && editFromPanel |=> rangeSel == $past(autoRange))
        else $error("panel entry did not select range");

    a_remote_range: assert property (
        editConfirm && !editFromPanel && !rangeWr |=> $stable(rangeSel))
        else $error("remote entry changed range");

    a_zero_accept: assert property (
        measBusy && measDone && s_reg.isZero && !measFault && !overRangePositive
        && !overRangeNegative && measValue <= ZERO_LIMIT
        |=> offsetVal == $past(measValue))
        else $error("offset within limit not stored");

    a_zero_reject: assert property (
        measBusy && measDone && s_reg.isZero && measValue > ZERO_LIMIT
        |=> zeroErr && $stable(offsetVal))
        else $error("large offset not rejected");

    a_ovr_hi: assert property (
        judgeCycle && compOn && compEnable && !measFault && overRangePositive
        |=> judgeHi && judgeValid)
        else $error("positive over-range not judged Hi");

    a_fault_quiet: assert property (
        judgeCycle && measFault |=> !judgeValid && faultOut)
        else $error("fault produced a judgment");

    a_need_limits: assert property (
        !limitsValid |-> !judgeValid)
        else $error("judgment before limits set");

    a_hold_limits: assert property (
        !editConfirm |=> $stable(s_reg.limHi) && $stable(s_reg.limLo))
        else $error("limits changed without confirmation");

    a_beep_gate: assert property (
        beep |-> $past(s_reg.beepEn))
        else $error("tone without enable");

    a_comp_off: assert property (
        !compEnable |=> !judgeValid ##1 !judgeValid || compEnable)
        else $error("judgment with comparator off");

    a_judge_onehot: assert property (
        judgeValid ? $onehot({judgeHi, judgeIn, judgeLo}) : !(judgeHi | judgeIn | judgeLo))
        else $error("judgment outputs not one-hot");

    c_ext_meas: cover property (measStart && externalTriggerSource && !measZero);
    c_judge_in: cover property (judgeValid && judgeIn);
    c_zero_err: cover property ($rose(zeroErr));
    c_fault:    cover property ($rose(faultOut));

endmodule : mtj_meter_ctrl

// file: hdl/mtj_pkg.sv
// shared constants and types for the meter trigger, range and judgment control
package mtj_pkg;

    localparam int VAL_W  = 48;
    localparam int NRANGE = 16;

    // resistance values are unsigned, in units of 10 micro-ohm
    typedef logic [VAL_W-1:0] mtj_val_t;
    typedef logic [3:0]       mtj_range_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MEAS
    } mtj_state_t;

    // range index: 0=100m 1=1000m 2=3 3=10 4=100 5=300 6=1000 ohm,
    // 7=10k 8=30k 9=100k 10=300k 11=1000k 12=3M 13=10M 14=30M 15=100M
    localparam mtj_range_t RANGE_LP_MIN = 4'h1;
    localparam mtj_range_t RANGE_LP_MAX = 4'h6;
    localparam mtj_range_t RANGE_TOP    = 4'hf;
    localparam mtj_range_t RANGE_RESET  = 4'h3;

    // inclusive upper bound of each range, normal mode
    localparam mtj_val_t BOUND_NORM [NRANGE] = '{
        48'd10009,         48'd100090,         48'd300900,
        48'd1000900,       48'd10009000,       48'd30090000,
        48'd100090000,     48'd1000900000,     48'd3009000000,
        48'd10009000000,   48'd30090000000,    48'd100090000000,
        48'd300900000000,  48'd1000900000000,  48'd3009000000000,
        48'd12000000000000
    };

    // inclusive upper bound of each range, voltage limiting on
    localparam mtj_val_t BOUND_VLIM [NRANGE] = '{
        48'd10009,         48'd100090,         48'd300900,
        48'd1000900,       48'd10009000,       48'd30090000,
        48'd100090000,     48'd500900000,      48'd1509000000,
        48'd5009000000,    48'd15090000000,    48'd50090000000,
        48'd150900000000,  48'd500900000000,   48'd1509000000000,
        48'd12000000000000
    };

    // top of the 1000 ohm range in reduced-power measuring (1200.0 ohm)
    localparam mtj_val_t BOUND_LP_TOP = 48'd120000000;

    // largest offset zero adjustment may cancel (10 ohm)
    localparam mtj_val_t ZERO_LIMIT = 48'd1000000;

endpackage : mtj_pkg

// file: hdl/mtj_range_select.sv
// automatic range choice from a reference or upper threshold value
`timescale 1ns/1ps
module mtj_range_select
    import mtj_pkg::*;
(
    input  wire mtj_val_t   value,
    input  wire logic       lowPower,
    input  wire logic       voltLimit,
    output mtj_range_t      rangeIdx
);

    logic [NRANGE-1:0] fits;
    mtj_range_t        idxLo;
    mtj_range_t        idxHi;

    genvar i;
    for (i = 0; i < NRANGE; i++) begin : g_bound
        mtj_val_t bound;
        // reduced power stretches the 1000 ohm range up to 1200 ohm
        assign bound = (lowPower && i == int'(RANGE_LP_MAX)) ? BOUND_LP_TOP :
                       (voltLimit && !lowPower) ? BOUND_VLIM[i] :
                       BOUND_NORM[i];
        assign fits[i] = (value <= bound);
    end

    assign idxLo = lowPower ? RANGE_LP_MIN : 4'h0;
    assign idxHi = lowPower ? RANGE_LP_MAX : RANGE_TOP;

    // smallest allowed range whose bound covers the value; above all, saturate
    always_comb begin
        rangeIdx = idxHi;
        for (int k = NRANGE - 1; k >= 0; k--) begin
            if (fits[k] && k >= int'(idxLo) && k <= int'(idxHi)) begin
                rangeIdx = mtj_range_t'(k);
            end
        end
    end

endmodule : mtj_range_select

// file: testbench/mtj_analog_model.sv
// behavioural analog measurement path answering each start pulse
`timescale 1ns/1ps
module mtj_analog_model
    import mtj_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic       measStart,
    input  wire logic [7:0] latency,
    input  wire mtj_val_t   setValue,
    input  wire logic [2:0] setFlags,
    output logic            measDone,
    output mtj_val_t        measValue,
    output logic            overRangePositive,
    output logic            overRangeNegative,
    output logic            measFault
);
    logic [7:0] waitCnt;
    logic [2:0] flagReg;
    logic       running;

    assign {overRangePositive, overRangeNegative, measFault} = flagReg;

    // results churn outside the done cycle so a stale sample cannot pass
    always @(posedge clk_sys) begin
        measDone <= 1'b0;
        measValue <= ~measValue;
        flagReg <= ~flagReg;
        if (!rst_b) begin
            running <= 1'b0;
            waitCnt <= 8'h00;
            measValue <= '0;
            flagReg <= 3'h0;
        end else if (measStart) begin
            running <= 1'b1;
            waitCnt <= latency;
        end else if (running && waitCnt != 8'h00) begin
            waitCnt <= waitCnt - 8'h01;
        end else if (running) begin
            running <= 1'b0;
            measDone <= 1'b1;
            measValue <= setValue;
            flagReg <= setFlags;
        end
    end
endmodule : mtj_analog_model

// file: testbench/testbench.sv
// self-checking bench for the meter control block
`timescale 1ns/1ps
module testbench
    import mtj_pkg::*;
;
    logic       clk_sys, rst_b, externalTriggerSource, contMeasure, externalTriggerInput;
    logic       remoteTrig, hostArm, autoMemReq, lowPower, voltLimit, rangeWr, compEnable;
    logic       editRefMode, editFromPanel, editConfirm, zeroStart, zeroErrClr, beepEnWr;
    logic       beepEnVal, measDone, overRangePositive, overRangeNegative, measFault;
    logic       measStart, measBusy, measZero, autoMemEn, storeTrig, zeroErr, limitsValid;
    logic       judgeHi, judgeIn, judgeLo, judgeValid, faultOut, beep;
    logic [2:0] setFlags;
    logic [7:0] latency;
    mtj_range_t rangeVal, rangeSel;
    mtj_val_t   editUpper, editLower, editRef, measValue, offsetVal, setValue;
    int         failures = 0, tests_run = 0, cycles = 0, starts = 0, stores = 0, beeps = 0;

    mtj_meter_ctrl DUT (
        .clk_sys, .rst_b, .externalTriggerSource, .contMeasure, .externalTriggerInput,
        .remoteTrig, .hostArm, .autoMemReq, .lowPower, .voltLimit, .rangeWr, .rangeVal,
        .compEnable, .editUpper, .editLower, .editRef, .editRefMode, .editFromPanel,
        .editConfirm, .zeroStart, .zeroErrClr, .beepEnWr, .beepEnVal, .measDone, .measValue,
        .overRangePositive, .overRangeNegative, .measFault, .measStart, .measBusy, .measZero,
        .rangeSel, .autoMemEn, .storeTrig, .offsetVal, .zeroErr, .limitsValid, .judgeHi,
        .judgeIn, .judgeLo, .judgeValid, .faultOut, .beep
    );

    mtj_analog_model analog (
        .clk_sys, .rst_b, .measStart, .latency, .setValue, .setFlags, .measDone,
        .measValue, .overRangePositive, .overRangeNegative, .measFault
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // pulse outputs are counted here so no single cycle is missed
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        starts <= starts + int'(measStart);
        stores <= stores + int'(storeTrig);
        beeps <= beeps + int'(beep);
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : tick

    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask : pulse

    task automatic judged(input logic [3:0] e);
        check({judgeHi, judgeIn, judgeLo, judgeValid}, e);
    endtask : judged

    task automatic confirm(input mtj_val_t u, input mtj_val_t l, input logic panel);
        editUpper = u;
        editLower = l;
        editFromPanel = panel;
        pulse(editConfirm);
        tick(1);
    endtask : confirm

    // fl is {zero run, over-range plus, over-range minus, fault}
    task automatic measure(input mtj_val_t v, input logic [3:0] fl);
        int s;
        s = starts;
        setValue = v;
        setFlags = fl[2:0];
        if (fl[3]) pulse(zeroStart);
        else pulse(remoteTrig);
        for (int i = 0; i < 40 && measDone !== 1'b1; i++) tick(1);
        check(measBusy, 1'b1);
        tick(2);
        check(starts - s, 1);
        check(measBusy, 1'b0);
        check(measZero, fl[3]);
    endtask : measure

    task automatic t_internal();
        int s;
        int t;
        s = starts;
        t = stores;
        autoMemReq = 1'b1;
        pulse(remoteTrig);
        tick(10);
        check(autoMemEn, 1'b1);
        check(starts - s, 0);
        check(stores - t, 1);
        contMeasure = 1'b1;
        tick(60);
        contMeasure = 1'b0;
        tick(12);
        check(starts - s >= 8, 1'b1);
        s = starts;
        pulse(hostArm);
        tick(15);
        check(starts - s, 1);
    endtask : t_internal

    task automatic t_external();
        int s;
        externalTriggerSource = 1'b1;
        contMeasure = 1'b1;
        autoMemReq = 1'b1;
        compEnable = 1'b1;
        tick(2);
        check(autoMemEn, 1'b0);
        s = starts;
        externalTriggerInput = 1'b1;
        tick(4);
        externalTriggerInput = 1'b0;
        tick(15);
        check(starts - s, 1);
        judged(4'b0000);
        contMeasure = 1'b0;
        pulse(remoteTrig);
        tick(10);
        check(starts - s, 1);
        pulse(hostArm);
        pulse(remoteTrig);
        tick(15);
        check(starts - s, 2);
        contMeasure = 1'b1;
    endtask : t_external

    task automatic t_range();
        mtj_val_t   v [12] = '{48'h2719, 48'h271a, 48'hf45c4, 48'h2bcd1fb1400, 48'hae9f7bcc000,
                               48'h1ddb20a1, 48'h1ddb20a0, 48'h1ddb20a1, 48'h2719, 48'h0,
                               48'h1cb4a20, 48'h7270e00};
        logic [5:0] c [12] = '{6'h00, 6'h01, 6'h03, 6'h0f, 6'h0f, 6'h07,
                               6'h17, 6'h18, 6'h21, 6'h21, 6'h26, 6'h26};
        for (int i = 0; i < 12; i++) begin
            {lowPower, voltLimit} = c[i][5:4];
            confirm(v[i], 48'h0, 1'b1);
            check(rangeSel, c[i][3:0]);
        end
        {lowPower, voltLimit} = 2'b00;
        editRefMode = 1'b1;
        editRef = 48'h2719;
        confirm(48'hae9f7bcc000, 48'h0, 1'b1);
        check(rangeSel, 4'h0);
        editRefMode = 1'b0;
        rangeVal = 4'h9;
        pulse(rangeWr);
        tick(1);
        confirm(48'h2719, 48'h0, 1'b0);
        check(rangeSel, 4'h9);
        check(limitsValid, 1'b1);
    endtask : t_range

    task automatic t_judge();
        mtj_val_t   v [7] = '{48'h3e9, 48'h3e8, 48'h1f4, 48'h1f3, 48'h0, 48'h7d0, 48'h2bc};
        logic [2:0] f [7] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h2, 3'h1};
        logic [3:0] e [7] = '{4'h9, 4'h5, 4'h5, 4'h3, 4'h9, 4'h3, 4'h0};
        int         b;
        confirm(48'h3e8, 48'h1f4, 1'b0);
        for (int i = 0; i < 7; i++) begin
            measure(v[i], {1'b0, f[i]});
            judged(e[i]);
            check(faultOut, f[i][0]);
        end
        // edited but never confirmed, so the old upper limit must still apply
        editUpper = 48'h1388;
        measure(48'h7d0, 4'h0);
        judged(4'h9);
        b = beeps;
        measure(48'h2bc, 4'h0);
        check(beeps - b, 0);
        beepEnVal = 1'b1;
        pulse(beepEnWr);
        measure(48'h2bc, 4'h0);
        check(beeps - b, 1);
        compEnable = 1'b0;
        measure(48'h2bc, 4'h0);
        judged(4'h0);
        compEnable = 1'b1;
    endtask : t_judge

    task automatic t_zero();
        measure(48'hf4240, 4'h8);
        check(offsetVal, 48'hf4240);
        check(zeroErr, 1'b0);
        measure(48'hf4241, 4'h8);
        check(offsetVal, 48'hf4240);
        check(zeroErr, 1'b1);
        pulse(zeroErrClr);
        tick(1);
        check(zeroErr, 1'b0);
        measure(48'hf44fc, 4'h0);
        judged(4'h5);
    endtask : t_zero

    initial begin
        {externalTriggerSource, contMeasure, externalTriggerInput, remoteTrig, hostArm} = '0;
        {autoMemReq, lowPower, voltLimit, rangeWr, compEnable, editRefMode} = '0;
        {editFromPanel, editConfirm, zeroStart, zeroErrClr, beepEnWr, beepEnVal} = '0;
        {rangeVal, editUpper, editLower, editRef, setValue, setFlags} = '0;
        latency = 8'h03;
        rst_b = 1'b0;
        tick(16);
        rst_b = 1'b1;
        tick(1);
        check(rangeSel, 4'h3);
        check({limitsValid, zeroErr, judgeValid, beep}, 4'h0);
        t_internal();
        t_external();
        t_range();
        t_judge();
        t_zero();
        tally_and_finish();
    end
endmodule : testbench
